// *** dpcc_pkg.sv ***
// Package of constants for the power-down and clock control block
`default_nettype none
package dpcc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TXP_NS = 8;
  localparam int TXP_CYC = (TXP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_VALID_CYC = 2;
  localparam logic [3:0] RESUME_CYC = 4'(CLK_VALID_CYC + TXP_CYC);
  localparam logic [3:0] CNT_ZERO = 4'h0;
  // ----------------------------------------
  // Command encodings on CA2..CA0
  // ----------------------------------------
  localparam logic [2:0] CA_NOP = 3'h7;
  localparam logic [2:0] CA_DPD = 3'h3;
  // ----------------------------------------
  // Power states
  // ----------------------------------------
  typedef enum logic [1:0] {
    DPCC_ACTIVE = 2'b00,
    DPCC_PD = 2'b01,
    DPCC_DPD = 2'b11,
    DPCC_WAKE = 2'b10
  } dpcc_state_e;
endpackage : dpcc_pkg
`default_nettype wire

// *** dpcc_cmd_decode.sv ***
// Command decoder for power-state and no-operation commands
`default_nettype none
module dpcc_cmd_decode (
  input wire logic cke_prev,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [2:0] ca,
  output logic nop,
  output logic dpd_entry,
  output logic pd_entry,
  output logic exit_cmd
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    nop = (cke_prev == cke) &&
          (cs_n || (ca == dpcc_pkg::CA_NOP));
    dpd_entry = cke_prev && !cke && !cs_n &&
                (ca == dpcc_pkg::CA_DPD);
    pd_entry = cke_prev && !cke && cs_n;
    exit_cmd = !cke_prev && cke;
  end
endmodule : dpcc_cmd_decode
`default_nettype wire

// *** dpcc_top.sv ***
// Device-side power-down, deep power-down and clock stop control
`default_nettype none
module dpcc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [2:0] ca,
  input wire logic clk_restart,
  input wire logic op_busy,
  output logic in_buf_en_r,
  output logic out_buf_en_r,
  output logic core_pwr_en_r,
  output logic cmd_ready_r,
  output logic nop_seen_r,
  output logic need_init_r,
  output logic array_lost_r,
  output logic op_run_r,
  output logic [1:0] pstate_r
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic cke_prev_r;
  logic nop;
  logic dpd_entry;
  logic pd_entry;
  logic exit_cmd;
  dpcc_pkg::dpcc_state_e state_r;
  dpcc_pkg::dpcc_state_e state_nxt;
  logic [3:0] wait_r;
  logic [3:0] wait_nxt;

  dpcc_cmd_decode u_dec (
    .cke_prev(cke_prev_r),
    .cke(cke),
    .cs_n(cs_n),
    .ca(ca),
    .nop(nop),
    .dpd_entry(dpd_entry),
    .pd_entry(pd_entry),
    .exit_cmd(exit_cmd)
  );

  // Previous CKE, follows the pin through reset
  always_ff @(posedge clk) begin
    cke_prev_r <= cke;
  end

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    case (state_r)
      dpcc_pkg::DPCC_ACTIVE: begin
        if (dpd_entry) begin
          state_nxt = dpcc_pkg::DPCC_DPD;
        end else if (pd_entry) begin
          state_nxt = dpcc_pkg::DPCC_PD;
        end else if (clk_restart && cke) begin
          state_nxt = dpcc_pkg::DPCC_WAKE;
          wait_nxt = dpcc_pkg::RESUME_CYC;
        end
      end
      dpcc_pkg::DPCC_PD: begin
        if (exit_cmd) begin
          state_nxt = dpcc_pkg::DPCC_WAKE;
          wait_nxt = dpcc_pkg::RESUME_CYC;
        end
      end
      dpcc_pkg::DPCC_DPD: begin
        if (exit_cmd) begin
          state_nxt = dpcc_pkg::DPCC_WAKE;
          wait_nxt = dpcc_pkg::RESUME_CYC;
        end
      end
      dpcc_pkg::DPCC_WAKE: begin
        if (!cke) begin
          state_nxt = dpcc_pkg::DPCC_PD;
        end else if (wait_r == dpcc_pkg::CNT_ZERO) begin
          state_nxt = dpcc_pkg::DPCC_ACTIVE;
        end else begin
          wait_nxt = wait_r - 4'h1;
        end
      end
      default: begin
        state_nxt = dpcc_pkg::DPCC_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= dpcc_pkg::DPCC_ACTIVE;
      wait_r <= dpcc_pkg::CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
    end
  end

  // ----------------------------------------
  // Buffers and power
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      in_buf_en_r <= 1'b1;
      out_buf_en_r <= 1'b1;
      core_pwr_en_r <= 1'b1;
      cmd_ready_r <= 1'b1;
      pstate_r <= 2'h0;
    end else begin
      in_buf_en_r <= (state_nxt != dpcc_pkg::DPCC_DPD) &&
                     (state_nxt != dpcc_pkg::DPCC_PD);
      out_buf_en_r <= (state_nxt != dpcc_pkg::DPCC_DPD) &&
                      (state_nxt != dpcc_pkg::DPCC_PD);
      core_pwr_en_r <= (state_nxt != dpcc_pkg::DPCC_DPD);
      cmd_ready_r <= (state_nxt == dpcc_pkg::DPCC_ACTIVE);
      pstate_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Initialization and data loss
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      need_init_r <= 1'b0;
      array_lost_r <= 1'b0;
    end else if (state_nxt == dpcc_pkg::DPCC_DPD) begin
      need_init_r <= 1'b1;
      array_lost_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // NOP and running operations
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      nop_seen_r <= 1'b0;
      op_run_r <= 1'b0;
    end else begin
      nop_seen_r <= nop;
      // A NOP leaves a burst running
      op_run_r <= op_busy && (state_nxt != dpcc_pkg::DPCC_DPD);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_DPD_ENTRY: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == dpcc_pkg::DPCC_ACTIVE) && dpd_entry |=>
    (state_r == dpcc_pkg::DPCC_DPD) && !core_pwr_en_r)
    else $error("deep power-down not entered");
  AST_DPD_BUFS: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == dpcc_pkg::DPCC_DPD) |->
    !in_buf_en_r && !out_buf_en_r)
    else $error("buffers on in deep power-down");
  AST_DPD_STAY: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == dpcc_pkg::DPCC_DPD) && !cke |=>
    (state_r == dpcc_pkg::DPCC_DPD) && !core_pwr_en_r)
    else $error("deep power-down left with CKE low");
  AST_LOST: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == dpcc_pkg::DPCC_ACTIVE) && dpd_entry |=>
    array_lost_r && need_init_r)
    else $error("loss flags late on deep entry");
  AST_PD_ENTRY: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == dpcc_pkg::DPCC_ACTIVE) && pd_entry |=>
    (state_r == dpcc_pkg::DPCC_PD) && core_pwr_en_r)
    else $error("power-down not entered");
  AST_PD_BUFS: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == dpcc_pkg::DPCC_PD) |->
    !in_buf_en_r && !out_buf_en_r && core_pwr_en_r)
    else $error("buffer state wrong in power-down");
  AST_PD_STAY: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == dpcc_pkg::DPCC_PD) && !cke |=>
    (state_r == dpcc_pkg::DPCC_PD))
    else $error("power-down left with CKE low");
  AST_PD_EXIT: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == dpcc_pkg::DPCC_PD) && exit_cmd |=>
    (state_r == dpcc_pkg::DPCC_WAKE))
    else $error("power-down not exited");
  AST_RESUME: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == dpcc_pkg::DPCC_PD) && exit_cmd ##1 cke [*4] |=>
    cmd_ready_r)
    else $error("not ready after resume time");
  AST_NO_EARLY: assert property (@(posedge clk) disable iff (!nrst)
    $rose(state_r == dpcc_pkg::DPCC_WAKE) |-> !cmd_ready_r [*4])
    else $error("ready too early");
  AST_RESTART: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == dpcc_pkg::DPCC_ACTIVE) && clk_restart && cke |=>
    (state_r == dpcc_pkg::DPCC_WAKE) && !cmd_ready_r)
    else $error("clock restart not waited");
  AST_NOP_CKE: assert property (@(posedge clk) disable iff (!nrst)
    (cke != $past(cke)) |=> !nop_seen_r)
    else $error("NOP with CKE change");
  AST_NOP_CS: assert property (@(posedge clk) disable iff (!nrst)
    (cke == cke_prev_r) && cs_n |=> nop_seen_r)
    else $error("CS_n high NOP missed");
  AST_INIT: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == dpcc_pkg::DPCC_DPD) |=> need_init_r && array_lost_r)
    else $error("reinit flag not set");
  AST_NOP_RUN: assert property (@(posedge clk) disable iff (!nrst)
    op_busy && nop && (state_r == dpcc_pkg::DPCC_ACTIVE) |=> op_run_r)
    else $error("NOP stopped operation");
endmodule : dpcc_top
`default_nettype wire

// *** dpcc_ctrl_model.sv ***
// Controller model driving clock enable, select and CA
`default_nettype none
module dpcc_ctrl_model (
  input wire logic clk,
  output var logic cke,
  output var logic cs_n,
  output var logic [2:0] ca
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle cycles covering command to CKE low spacing
  localparam int ENTRY_GAP = 8;
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    ca = 3'h7;
  end
  // One command per cycle
  task automatic send(input logic k, input logic s, input logic [2:0] a);
    @(negedge clk);
    cke <= k;
    cs_n <= s;
    ca <= a;
  endtask : send
  // Idle high cycles, then entry
  task automatic enter(input logic deep);
    repeat (ENTRY_GAP) begin
      send(1'h1, 1'h1, dpcc_pkg::CA_NOP);
    end
    send(1'h0, ~deep, deep ? dpcc_pkg::CA_DPD : dpcc_pkg::CA_NOP);
  endtask : enter
  // Low hold with NOPs, clock kept
  task automatic hold(input int n);
    repeat (n) begin
      send(1'h0, 1'h1, dpcc_pkg::CA_NOP);
    end
  endtask : hold
  // Exit with select high
  task automatic wake();
    send(1'h1, 1'h1, dpcc_pkg::CA_NOP);
  endtask : wake
endmodule : dpcc_ctrl_model
`default_nettype wire

// *** dpcc_tb_top.sv ***
// Testbench for the power-down and clock control block
`default_nettype none
module dpcc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_restart = 1'b0;
  logic op_busy = 1'b0;
  wire logic cke;
  wire logic cs_n;
  wire logic [2:0] ca;
  logic ib, ob, pw, rdy, nop, ini, lost, run;
  logic [1:0] ps;
  int bad_count = 0;
  int compares = 0;
  // {cs_n, ca, op_busy, nop expected, run expected}
  logic [6:0] rows [5] = '{7'h47, 7'h3A, 7'h30, 7'h1D, 7'h7A};
  always #12.5 clk = ~clk;
  dpcc_ctrl_model dpcc_ctrl_model_inst (.clk(clk), .cke(cke),
    .cs_n(cs_n), .ca(ca));
  dpcc_top dpcc_top_inst (.clk(clk), .nrst(nrst), .cke(cke), .cs_n(cs_n),
    .ca(ca), .clk_restart(clk_restart), .op_busy(op_busy),
    .in_buf_en_r(ib), .out_buf_en_r(ob), .core_pwr_en_r(pw),
    .cmd_ready_r(rdy), .nop_seen_r(nop), .need_init_r(ini),
    .array_lost_r(lost), .op_run_r(run), .pstate_r(ps));
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %b want %b", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("compares %0d, bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  // Wake walk back to active
  task automatic wake_walk();
    tick();
    check(ps, dpcc_pkg::DPCC_WAKE);
    check({1'b0, rdy}, 2'h0);
    check({1'b0, ib}, 2'h1);
    @(negedge clk);
    clk_restart <= 1'b0;
    repeat (dpcc_pkg::RESUME_CYC) @(posedge clk);
    #1;
    check({1'b0, rdy}, 2'h0);
    tick();
    check(ps, dpcc_pkg::DPCC_ACTIVE);
    check({1'b0, rdy}, 2'h1);
  endtask : wake_walk
  initial begin
    #(400 * dpcc_pkg::CLK_PERIOD_NS);
    bad_count++;
    give_verdict();
  end
  initial begin
    tick();
    check({1'b0, pw}, 2'h1);
    check({1'b0, lost}, 2'h0);
    repeat (3) @(negedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      dpcc_ctrl_model_inst.send(1'h1, rows[i][6], rows[i][5:3]);
      op_busy <= rows[i][2];
      tick();
      check({1'b0, nop}, {1'b0, rows[i][1]});
      check({1'b0, run}, {1'b0, rows[i][0]});
      check(ps, dpcc_pkg::DPCC_ACTIVE);
    end
    $display("row tests done");
    dpcc_ctrl_model_inst.enter(1'h0);
    tick();
    check(ps, dpcc_pkg::DPCC_PD);
    check({1'b0, ob}, 2'h0);
    check({1'b0, pw}, 2'h1);
    dpcc_ctrl_model_inst.hold(2);
    check({1'b0, nop}, 2'h1);
    dpcc_ctrl_model_inst.wake();
    wake_walk();
    $display("power-down test done");
    @(negedge clk);
    dpcc_ctrl_model_inst.enter(1'h1);
    tick();
    check(ps, dpcc_pkg::DPCC_DPD);
    check({1'b0, pw}, 2'h0);
    check({1'b0, ib}, 2'h0);
    check({1'b0, lost}, 2'h1);
    check({1'b0, ini}, 2'h1);
    dpcc_ctrl_model_inst.hold(1);
    op_busy <= 1'b1;
    dpcc_ctrl_model_inst.hold(1);
    check({1'b0, run}, 2'h0);
    op_busy <= 1'b0;
    dpcc_ctrl_model_inst.wake();
    wake_walk();
    check({1'b0, ini}, 2'h1);
    $display("deep power-down test done");
    @(negedge clk);
    clk_restart <= 1'b1;
    wake_walk();
    $display("clock restart test done");
    @(negedge clk);
    nrst <= 1'b0;
    tick();
    check({1'b0, ini}, 2'h0);
    check({1'b0, lost}, 2'h0);
    $display("reset test done");
    give_verdict();
  end
endmodule : dpcc_tb_top
`default_nettype wire
